/* File: bdc_pkg.sv */
package bdc_pkg;
	// ****************************************
	// register offsets and reset values
	// ****************************************
	localparam logic [7:0]  DIAG_ZERO_OFFSET  = 8'hC0;
	localparam logic [7:0]  DIAG_ONE_OFFSET   = 8'hC4;
	localparam logic [31:0] DIAG_ZERO_RESET   = 32'h00000001;
	localparam logic [31:0] DIAG_ONE_RESET    = 32'h00120108;
	localparam logic [2:0]  SLEEP_EXIT_LAT_RESET = 3'h4;
	// writable bits; everything else reads zero except the captured bus and device numbers
	localparam logic [31:0] DIAG_ZERO_WMASK   = 32'h0004CF87;
	localparam logic [31:0] DIAG_ONE_WMASK    = 32'h001FFFFF;
	// reserved writable bits, kept but never steer anything
	localparam logic [31:0] DIAG_ZERO_RSVD_RW = 32'h0000CF82;
	localparam logic [31:0] DIAG_ONE_RSVD_RW  = 32'h00007803;
	// ****************************************
	// field positions
	// ****************************************
	localparam int BUS_NUM_LSB     = 24;
	localparam int DEV_NUM_LSB     = 19;
	localparam int ADV_ERR_BIT     = 18;
	localparam int CFG_ACCESS_BIT  = 2;
	localparam int CLKREQ_HOLD_BIT = 0;
	localparam int LAT_SEP_LSB     = 18;
	localparam int LAT_SHR_LSB     = 15;
	localparam int DS_RST_SUPP_BIT = 10;
	localparam int SLEEP_TMR_LSB   = 6;
	localparam int STBY_TMR_LSB    = 2;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS      = 10000;
	localparam int SLEEP_TICK_PS      = 512000;
	localparam int STBY_TICK_PS       = 16000;
	localparam int SLEEP_TICK_CYCLES  = SLEEP_TICK_PS / CLK_PERIOD_PS;
	localparam int STBY_TICK_CYCLES   = STBY_TICK_PS / CLK_PERIOD_PS;
endpackage

/* File: bdc_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// - upstream bus number read-only in top byte
// - upstream device number read-only below it
// - advisory error disable bit, zero means supported
// - enable lets config cycles reach memory registers
// - clock request hold forces clkreq, resets one
// - read-only reserved bits read zero, ignore writes
// - writable reserved bits reset zero, write zeros
// - shared clock set mirrors separate-clock latency
// - shared clock clear mirrors shared-clock latency
// - suppress bit masks downstream reset, resets zero
// - sleep entry timer counts 510 ns units (51 clock cycles)
// - standby entry timer counts 10 ns clock cycles
// - fundamental, global, power-on reset restore defaults
// - second register at C4h, reset 00120108h
// - first register at C0h, reset 00000001h
module bdc_regs
	import bdc_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        NRST,
	input  wire logic        PERST_N,
	input  wire logic        GLOBAL_RESET_INPUT_N,
	input  wire logic        CFG_WR,
	input  wire logic        CFG_RD,
	input  wire logic [7:0]  CFG_ADDR,
	input  wire logic [3:0]  CFG_BE,
	input  wire logic [31:0] CFG_WDATA,
	input  wire logic        CAPTURE_VALID,
	input  wire logic [7:0]  CAPTURE_BUS,
	input  wire logic [4:0]  CAPTURE_DEVICE,
	input  wire logic        SHARED_CLOCK_CONFIG,
	input  wire logic        DOWNSTREAM_RESET_BIT,
	input  wire logic        MEM_REG_CFG_HIT,
	input  wire logic        LINK_ACTIVE,
	output logic [31:0]      CFG_RDATA,
	output logic             CFG_ACK,
	output logic             CLKREQ_N,
	output logic             ADVISORY_ERROR_DISABLE,
	output logic             MEM_REG_CFG_ALLOW,
	output logic             DOWNSTREAM_RESET,
	output logic [2:0]       ADVERTISED_SLEEP_EXIT_LATENCY,
	output logic             SLEEP_ENTRY_OK,
	output logic             STANDBY_ENTRY_OK
);
	// ****************************************
	// reset release
	// ****************************************
	logic       rst_a_r;
	logic       rst_b_r;
	logic       rst_n;
	// any of the three resets restores defaults
	assign rst_n = NRST & PERST_N & GLOBAL_RESET_INPUT_N;

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			rst_a_r <= 1'b0;
			rst_b_r <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_b_r <= rst_a_r;
		end
	end

	// ****************************************
	// register storage
	// ****************************************
	logic [31:0] zero_r;
	logic [31:0] one_r;
	logic [31:0] zero_nxt;
	logic [31:0] one_nxt;
	logic        hit_zero;
	logic        hit_one;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] lanes;
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		merge = (old & ~lanes) | (wd & lanes);
	endfunction

	assign hit_zero = (CFG_ADDR == DIAG_ZERO_OFFSET);
	assign hit_one  = (CFG_ADDR == DIAG_ONE_OFFSET);

	always_comb begin
		zero_nxt = zero_r;
		one_nxt  = one_r;
		if (CFG_WR && hit_zero) begin
			// only writable bits change; read-only reserved stay zero
			zero_nxt = merge(zero_r, CFG_WDATA, CFG_BE, DIAG_ZERO_WMASK);
		end
		if (CFG_WR && hit_one) begin
			one_nxt = merge(one_r, CFG_WDATA, CFG_BE, DIAG_ONE_WMASK);
		end
		// captured numbers come from traffic, never from writes
		if (CAPTURE_VALID) begin
			zero_nxt[BUS_NUM_LSB +: 8] = CAPTURE_BUS;
			zero_nxt[DEV_NUM_LSB +: 5] = CAPTURE_DEVICE;
		end
	end

	// reserved writable bits come out of reset as zero
	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			zero_r <= DIAG_ZERO_RESET;
			one_r  <= DIAG_ONE_RESET;
		end else begin
			zero_r <= zero_nxt;
			one_r  <= one_nxt;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// every request answered next cycle; no wait states to track
	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			CFG_ACK <= 1'b0;
		end else begin
			CFG_ACK <= CFG_RD | CFG_WR;
		end
	end

	// unmapped offsets and writes read zero
	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			CFG_RDATA <= 32'h00000000;
		end else begin
			if (CFG_RD && hit_zero) begin
				CFG_RDATA <= zero_r;
			end else if (CFG_RD && hit_one) begin
				CFG_RDATA <= one_r;
			end else begin
				CFG_RDATA <= 32'h00000000;
			end
		end
	end

	// ****************************************
	// field views
	// ****************************************
	logic       hold_bit;
	logic       adv_bit;
	logic       access_bit;
	logic       suppress_bit;
	logic [2:0] lat_separate;
	logic [2:0] lat_shared;
	logic [2:0] latency_sel;
	logic [3:0] sleep_lim;
	logic [3:0] stby_lim;

	assign hold_bit     = zero_r[CLKREQ_HOLD_BIT];
	assign adv_bit      = zero_r[ADV_ERR_BIT];
	assign access_bit   = zero_r[CFG_ACCESS_BIT];
	assign suppress_bit = one_r[DS_RST_SUPP_BIT];
	assign lat_separate = one_r[LAT_SEP_LSB +: 3];
	assign lat_shared   = one_r[LAT_SHR_LSB +: 3];
	assign sleep_lim    = one_r[SLEEP_TMR_LSB +: 4];
	assign stby_lim     = one_r[STBY_TMR_LSB +: 4];
	// link control bit picks which latency is advertised
	assign latency_sel  = SHARED_CLOCK_CONFIG ? lat_separate : lat_shared;

	// ****************************************
	// controls driven from the fields
	// ****************************************
	// hold low while set; otherwise released to the power logic
	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			CLKREQ_N <= 1'b0;
		end else begin
			CLKREQ_N <= ~hold_bit & ~LINK_ACTIVE;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			ADVISORY_ERROR_DISABLE <= 1'b0;
		end else begin
			ADVISORY_ERROR_DISABLE <= adv_bit;
		end
	end

	// gate only; the memory-mapped decode stays outside
	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			MEM_REG_CFG_ALLOW <= 1'b0;
		end else begin
			MEM_REG_CFG_ALLOW <= access_bit & MEM_REG_CFG_HIT;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			DOWNSTREAM_RESET <= 1'b0;
		end else begin
			DOWNSTREAM_RESET <= DOWNSTREAM_RESET_BIT & ~suppress_bit;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			ADVERTISED_SLEEP_EXIT_LATENCY <= SLEEP_EXIT_LAT_RESET;
		end else begin
			ADVERTISED_SLEEP_EXIT_LATENCY <= latency_sel;
		end
	end

	// ****************************************
	// entry timers
	// ****************************************
	logic [$clog2(SLEEP_TICK_CYCLES+1)-1:0] sleep_pre_r;
	logic [$clog2(STBY_TICK_CYCLES+1)-1:0]  stby_pre_r;
	logic [3:0] sleep_cnt_r;
	logic [3:0] stby_cnt_r;
	logic       sleep_tick;
	logic       stby_tick;

	assign sleep_tick = (sleep_pre_r == ($bits(sleep_pre_r))'(SLEEP_TICK_CYCLES - 1));
	// 62.5 MHz is not a whole divisor of 100 MHz; tick rounds down to one 10 ns cycle
	assign stby_tick  = (stby_pre_r == ($bits(stby_pre_r))'(STBY_TICK_CYCLES - 1));

	// activity restarts the prescalers and counts
	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			sleep_pre_r <= '0;
		end else if (LINK_ACTIVE) begin
			sleep_pre_r <= '0;
		end else begin
			sleep_pre_r <= sleep_tick ? '0 : sleep_pre_r + 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			stby_pre_r <= '0;
		end else if (LINK_ACTIVE) begin
			stby_pre_r <= '0;
		end else begin
			stby_pre_r <= stby_tick ? '0 : stby_pre_r + 1'b1;
		end
	end

	// counts saturate at the limit so a long idle never wraps
	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			sleep_cnt_r <= 4'h0;
		end else if (LINK_ACTIVE) begin
			sleep_cnt_r <= 4'h0;
		end else if (sleep_tick && sleep_cnt_r < sleep_lim) begin
			sleep_cnt_r <= sleep_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			stby_cnt_r <= 4'h0;
		end else if (LINK_ACTIVE) begin
			stby_cnt_r <= 4'h0;
		end else if (stby_tick && stby_cnt_r < stby_lim) begin
			stby_cnt_r <= stby_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			SLEEP_ENTRY_OK <= 1'b0;
		end else begin
			SLEEP_ENTRY_OK <= ~LINK_ACTIVE & (sleep_cnt_r >= sleep_lim);
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			STANDBY_ENTRY_OK <= 1'b0;
		end else begin
			STANDBY_ENTRY_OK <= ~LINK_ACTIVE & (stby_cnt_r >= stby_lim);
		end
	end
endmodule

/* File: bdc_regs_chk_asserts.sv */
`timescale 1ns/1ps
// ****
// config register checks
// ****
module bdc_regs_chk (
	input wire logic        CLOCK,
	input wire logic        NRST,
	input wire logic        PERST_N,
	input wire logic        GLOBAL_RESET_INPUT_N,
	input wire logic        CFG_RD,
	input wire logic [7:0]  CFG_ADDR,
	input wire logic [31:0] CFG_RDATA,
	input wire logic        CFG_ACK,
	input wire logic        CLKREQ_N,
	input wire logic        LINK_ACTIVE,
	input wire logic        SLEEP_ENTRY_OK,
	input wire logic        STANDBY_ENTRY_OK,
	input wire logic        ADVISORY_ERROR_DISABLE,
	input wire logic        MEM_REG_CFG_HIT,
	input wire logic        MEM_REG_CFG_ALLOW
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST || !PERST_N || !GLOBAL_RESET_INPUT_N);
	wire rd0 = CFG_RD && CFG_ADDR == 8'hC0;
	wire rd1 = CFG_RD && CFG_ADDR == 8'hC4;
	property p_ack; CFG_RD |=> CFG_ACK; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_rsv0; rd0 |=> (CFG_RDATA & 32'h00033078) == 32'h0; endproperty
	a_rsv0: assert property (p_rsv0) else $error("c0 reserved set");
	property p_rsv1; rd1 |=> CFG_RDATA[31:21] == 11'h0; endproperty
	a_rsv1: assert property (p_rsv1) else $error("c4 reserved set");
	property p_unm; CFG_RD && !rd0 && !rd1 |=> CFG_RDATA == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped data");
	property p_clk; rd0 ##1 CFG_RDATA[0] |-> !CLKREQ_N; endproperty
	a_clk: assert property (p_clk) else $error("clkreq not held");
	property p_adv; rd0 |=> ADVISORY_ERROR_DISABLE == CFG_RDATA[18]; endproperty
	a_adv: assert property (p_adv) else $error("advisory mismatch");
	property p_mem; rd0 && MEM_REG_CFG_HIT |=> MEM_REG_CFG_ALLOW == CFG_RDATA[2]; endproperty
	a_mem: assert property (p_mem) else $error("allow mismatch");
	property p_idle; LINK_ACTIVE[*2] |-> !SLEEP_ENTRY_OK && !STANDBY_ENTRY_OK; endproperty
	a_idle: assert property (p_idle) else $error("entry while active");
	cover property (rd0 ##1 CFG_RDATA[0]);
	cover property (LINK_ACTIVE[*2]);
	cover property (rd1);
endmodule
bind bdc_regs bdc_regs_chk u_chk (.*);

/* File: bdc_up.sv */
`timescale 1ns/1ps
// ****
// upstream config master
// ****
module bdc_up
	import bdc_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        CFG_ACK,
	input  wire logic [31:0] CFG_RDATA,
	output logic             CFG_WR = 1'h0,
	output logic             CFG_RD = 1'h0,
	output logic [7:0]       CFG_ADDR = 8'h0,
	output logic [3:0]       CFG_BE = 4'h0,
	output logic [31:0]      CFG_WDATA = 32'h0
);
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(negedge CLOCK);
		CFG_WR = w;
		CFG_RD = !w;
		CFG_ADDR = a;
		CFG_BE = 4'hF;
		CFG_WDATA = d & ~(a == 8'hC0 ? DIAG_ZERO_RSVD_RW : DIAG_ONE_RSVD_RW);
		@(negedge CLOCK);
		q = CFG_ACK === 1'h1 ? CFG_RDATA : 32'hX;
		CFG_WR = 1'h0;
		CFG_RD = 1'h0;
		// address and write data inverted so stale values never match
		CFG_ADDR = ~a;
		CFG_WDATA = ~CFG_WDATA;
	endtask
endmodule

/* File: tb_bdc_regs.sv */
`timescale 1ns/1ps
module tb_bdc_regs;
	logic NRST = 1'h0, PERST_N = 1'h1, GLOBAL_RESET_INPUT_N = 1'h1, CLOCK = 1'h0;
	logic CAPTURE_VALID = 1'h0, SHARED_CLOCK_CONFIG = 1'h0, DOWNSTREAM_RESET_BIT = 1'h0;
	logic MEM_REG_CFG_HIT = 1'h0, LINK_ACTIVE = 1'h0;
	logic [7:0] CAPTURE_BUS = 8'h0, CFG_ADDR;
	logic [4:0] CAPTURE_DEVICE = 5'h0;
	logic CFG_WR, CFG_RD, CFG_ACK, CLKREQ_N, ADVISORY_ERROR_DISABLE, MEM_REG_CFG_ALLOW;
	logic DOWNSTREAM_RESET, SLEEP_ENTRY_OK, STANDBY_ENTRY_OK;
	logic [3:0] CFG_BE;
	logic [31:0] CFG_WDATA, CFG_RDATA, q;
	logic [2:0] ADVERTISED_SLEEP_EXIT_LATENCY;
	int err_count = 0, cmp_count = 0;
	bdc_regs dut (.*);
	bdc_up up (.*);
	initial forever #5 CLOCK = ~CLOCK;
	initial begin
		#50000;
		err_count++;
		conclude;
	end
	task conclude;
		$display("errors %0d checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task ck(string n, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("Error %s exp %h got %h", n, e, s);
			err_count++;
		end
	endtask
	task cyc(int n);
		repeat (n) @(negedge CLOCK);
	endtask
	task wr(logic [7:0] a, logic [31:0] d);
		up.acc(1'h1, a, d, q);
		cyc(1);
	endtask
	task rd(logic [7:0] a, logic [31:0] e);
		up.acc(1'h0, a, 32'h0, q);
		ck("rdata", e, q);
	endtask
	task t_reset;
		rd(8'hC0, 32'h00000001);
		rd(8'hC4, 32'h00120108);
		rd(8'hC8, 32'h0);
		ck("clkreq_n", 0, CLKREQ_N);
		ck("latency", 4, ADVERTISED_SLEEP_EXIT_LATENCY);
	endtask
	task t_c0;
		MEM_REG_CFG_HIT = 1'h1;
		wr(8'hC0, 32'hFFFFFFFF);
		rd(8'hC0, 32'h00040005);
		ck("adv", 1, ADVISORY_ERROR_DISABLE);
		ck("allow", 1, MEM_REG_CFG_ALLOW);
		wr(8'hC0, 32'h0);
		ck("clkreq_n", 1, CLKREQ_N);
		ck("allow", 0, MEM_REG_CFG_ALLOW);
	endtask
	task t_cap;
		CAPTURE_BUS = 8'hA5;
		CAPTURE_DEVICE = 5'h1B;
		CAPTURE_VALID = 1'h1;
		cyc(1);
		CAPTURE_VALID = 1'h0;
		CAPTURE_BUS = 8'h5A;
		rd(8'hC0, {8'hA5, 5'h1B, 19'h0});
	endtask
	task t_c4;
		DOWNSTREAM_RESET_BIT = 1'h1;
		wr(8'hC4, 32'hFFEB0400);
		rd(8'hC4, 32'h000B0400);
		ck("ds_reset", 0, DOWNSTREAM_RESET);
		ck("latency", 6, ADVERTISED_SLEEP_EXIT_LATENCY);
		SHARED_CLOCK_CONFIG = 1'h1;
		cyc(2);
		ck("latency", 2, ADVERTISED_SLEEP_EXIT_LATENCY);
		wr(8'hC4, 32'h0);
		ck("ds_reset", 1, DOWNSTREAM_RESET);
	endtask
	task t_tmr;
		LINK_ACTIVE = 1'h1;
		wr(8'hC4, 32'h0000008C);
		ck("sleep", 0, SLEEP_ENTRY_OK);
		LINK_ACTIVE = 1'h0;
		cyc(2);
		ck("standby", 0, STANDBY_ENTRY_OK);
		cyc(4);
		ck("standby", 1, STANDBY_ENTRY_OK);
		cyc(54);
		ck("sleep", 0, SLEEP_ENTRY_OK);
		cyc(50);
		ck("sleep", 1, SLEEP_ENTRY_OK);
		LINK_ACTIVE = 1'h1;
		cyc(2);
		ck("standby", 0, STANDBY_ENTRY_OK);
	endtask
	task t_rst;
		for (int i = 0; i < 2; i++) begin
			wr(8'hC4, 32'h0);
			if (i == 0) PERST_N = 1'h0;
			else GLOBAL_RESET_INPUT_N = 1'h0;
			cyc(2);
			PERST_N = 1'h1;
			GLOBAL_RESET_INPUT_N = 1'h1;
			cyc(4);
			rd(8'hC4, 32'h00120108);
			rd(8'hC0, 32'h00000001);
		end
	endtask
	initial begin
		cyc(5);
		NRST = 1'h1;
		cyc(4);
		t_reset;
		t_c0;
		t_cap;
		t_c4;
		t_tmr;
		t_rst;
		conclude;
	end
endmodule
